// ### rtl/kwu_pkg.sv
// Purpose: Shared constants for the key-on wakeup block.
// Assumes: Register port with byte-wide data and a 12-bit address.
// Notes:   Offsets, field positions and the enable and read-data reset values live here.
package kwu_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 8;
    localparam int          NUM_KEYS        = 4;
    localparam logic [11:0] WAKE_EN_ADDR    = 12'hfaa;
    localparam logic [11:0] KWU_STATUS_ADDR = 12'hfab;
    localparam int          WAKE_EN_LSB     = 4;
    localparam logic [3:0]  WAKE_EN_RESET   = 4'h0;
    localparam logic [7:0]  READ_ZERO       = 8'h00;
    localparam int          ST_REQ_BIT      = 0;
    localparam int          ST_STOP_BIT     = 1;
    localparam int          ST_MODE_BIT     = 2;
    localparam int          ST_KEYS_LSB     = 4;
endpackage

// ### rtl/kwu_det_if.sv
// Purpose: Carries detector inputs and the release result between modules.
// Assumes: Single clock; the detector itself is combinational.
// Notes:   None.
`timescale 1ns/1ns
interface kwu_det_if;
    logic [3:0] key_enable;
    logic [3:0] key_level;
    logic       main_level;
    logic       main_rise;
    logic       level_mode;
    logic       key_request;
    logic       release_req;
    modport ctrl (output key_enable, key_level, main_level, main_rise, level_mode,
                  input key_request, release_req);
    modport det  (input key_enable, key_level, main_level, main_rise, level_mode,
                  output key_request, release_req);
endinterface

// ### rtl/kwu_release_det.sv
// Purpose: Forms the stop-release request from enables and pin levels.
// Assumes: Pure combinational logic, usable while the clock is halted.
// Notes:   Key pins only count in level-release mode.
`timescale 1ns/1ns
module kwu_release_det (
    kwu_det_if.det d
);
    logic [3:0] key_hit;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_key
            assign key_hit[g] = d.key_enable[g] & ~d.key_level[g];
        end
    endgenerate

    assign d.key_request = d.level_mode & (|key_hit);
    assign d.release_req = d.key_request
                         | (d.level_mode ? d.main_level : d.main_rise);
endmodule

// ### rtl/kwu_top.sv
// Purpose: Key-on wakeup unit: key pin enables and stop-mode release.
// Assumes: Pins synchronous to mclk; warm-up sequencer sits outside.
// Notes:   The enable register is write-only; a status word shows state.
`timescale 1ns/1ns
// How it works
// - Each of the four key pins has its own release enable bit.
// - Enables for key pins 5,4,3,2 sit in bits 7..4, reset to zero, low nibble unused.
// - The enable bits cannot be read back through their register.
// - In level mode an enabled key pin at low level releases stop.
// - The main release pin releases on high level in level mode, on a rising edge otherwise.
// - A release condition present at stop entry skips stop and starts warm-up at once.
// - Each key pin level is readable as port data.
module kwu_top (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [11:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [7:0]  rdata,
    input  wire logic [3:0]  key_wake_in,
    input  wire logic        main_release_in,
    input  wire logic        level_mode,
    input  wire logic        stop_entry,
    output logic             release_req,
    output logic             stop_active,
    output logic             warmup_start,
    output logic      [3:0]  key_port_data
);
    logic       rst_meta_reg;
    logic       rst_sync_reg;
    logic [3:0] wake_en_reg,  wake_en_next;
    logic [7:0] rdata_reg,    rdata_next;
    logic       stop_reg,     stop_next;
    logic       warm_reg,     warm_next;
    logic       main_prev_reg, main_prev_next;
    logic [3:0] port_reg,      port_next;
    logic       rst_n;

    kwu_det_if det_bus ();

    // Reset takes hold at once but is let go in step with mclk.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // The detector sees the pins directly, so a request forms with the clock halted.
    assign det_bus.key_enable = wake_en_reg;
    assign det_bus.key_level  = key_wake_in;
    assign det_bus.main_level = main_release_in;
    assign det_bus.main_rise  = main_release_in & ~main_prev_reg;
    assign det_bus.level_mode = level_mode;

    kwu_release_det u_det (
        .d (det_bus.det)
    );

    // Decodes one register address; shared by the port logic and its checks.
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] target);
        return a == target;
    endfunction

    // Register port: the enable nibble is write-only and a read answers for one cycle.
    always_comb begin
        wake_en_next = wake_en_reg;
        rdata_next   = kwu_pkg::READ_ZERO;
        if (wr_stb && addr_hit(addr, kwu_pkg::WAKE_EN_ADDR)) begin
            wake_en_next = wdata[kwu_pkg::WAKE_EN_LSB +: 4];
        end
        if (rd_stb && addr_hit(addr, kwu_pkg::KWU_STATUS_ADDR)) begin
            rdata_next[kwu_pkg::ST_REQ_BIT]       = det_bus.release_req;
            rdata_next[kwu_pkg::ST_STOP_BIT]      = stop_reg;
            rdata_next[kwu_pkg::ST_MODE_BIT]      = level_mode;
            rdata_next[kwu_pkg::ST_KEYS_LSB +: 4] = key_wake_in;
        end
        // A read of the enable address falls through to zero, so nothing leaks back.
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_en_reg <= kwu_pkg::WAKE_EN_RESET;
            rdata_reg   <= kwu_pkg::READ_ZERO;
        end else begin
            wake_en_reg <= wake_en_next;
            rdata_reg   <= rdata_next;
        end
    end

    // Stop sequencing. A request already present at entry never reaches stop, so
    // the part cannot halt with nothing left to wake it.
    always_comb begin
        stop_next = stop_reg;
        warm_next = 1'b0;
        if (stop_reg) begin
            if (det_bus.release_req) begin
                stop_next = 1'b0;
                warm_next = 1'b1;
            end
        end else if (stop_entry) begin
            if (det_bus.release_req) begin
                warm_next = 1'b1;
            end else begin
                stop_next = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stop_reg <= 1'b0;
            warm_reg <= 1'b0;
        end else begin
            stop_reg <= stop_next;
            warm_reg <= warm_next;
        end
    end

    // Pin samples: the previous main pin level for edge mode and the port data copy.
    always_comb begin
        main_prev_next = main_release_in;
        port_next      = key_wake_in;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_prev_reg <= 1'b0;
            port_reg      <= 4'h0;
        end else begin
            main_prev_reg <= main_prev_next;
            port_reg      <= port_next;
        end
    end

    assign rdata         = rdata_reg;
    assign release_req   = det_bus.release_req;
    assign stop_active   = stop_reg;
    assign warmup_start  = warm_reg;
    assign key_port_data = port_reg;

    AST_SKIP_STOP: assert property (@(posedge mclk) disable iff (!rst_n)
        (!stop_reg && stop_entry && release_req) |=> (!stop_reg && warmup_start))
        else $error("stop entered despite release");
    AST_ENABLE_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_stb && addr == kwu_pkg::WAKE_EN_ADDR) |=> (wake_en_reg == $past(wdata[7:4])))
        else $error("enable write lost");
    AST_WO_READ: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_stb && addr == kwu_pkg::WAKE_EN_ADDR) |=> (rdata == 8'h00))
        else $error("enable register readable");
    AST_KEY_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n)
        (level_mode && |(wake_en_reg & ~key_wake_in)) |-> release_req)
        else $error("enabled low key missed");
    AST_EDGE_KEYS: assert property (@(posedge mclk) disable iff (!rst_n)
        (!level_mode && !(main_release_in && !main_prev_reg)) |-> !release_req)
        else $error("edge mode false release");
    AST_MAIN_HIGH: assert property (@(posedge mclk) disable iff (!rst_n)
        (level_mode && main_release_in) |-> release_req)
        else $error("main high missed");
    AST_NO_REQ: assert property (@(posedge mclk) disable iff (!rst_n)
        (level_mode && !main_release_in && !(|(wake_en_reg & ~key_wake_in))) |-> !release_req)
        else $error("spurious release");
    AST_WAKE: assert property (@(posedge mclk) disable iff (!rst_n)
        (stop_reg && release_req) |=> (!stop_reg && warmup_start))
        else $error("stop not released");
    AST_PORT: assert property (@(posedge mclk) disable iff (!rst_n)
        rst_n |=> (key_port_data == $past(key_wake_in)))
        else $error("port data stale");

    // Stop entry with nothing pending must halt, and no warm-up may start by itself.
    AST_STOP_ENTER: assert property (@(posedge mclk) disable iff (!rst_n)
        (!stop_reg && stop_entry && !release_req) |=> (stop_reg && !warmup_start))
        else $error("stop not entered");

    AST_NO_WARM_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
        (!stop_reg && !stop_entry) |=> !warmup_start)
        else $error("warm-up without cause");

    AST_WARM_CAUSE: assert property (@(posedge mclk) disable iff (!rst_n)
        warmup_start |-> $past(release_req))
        else $error("warm-up without request");

    // Stop is left only through a release request.
    AST_STOP_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        (stop_reg && !release_req) |=> stop_reg)
        else $error("stop left without request");

    // The enables change only on a write to their own address.
    AST_EN_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        !(wr_stb && addr_hit(addr, kwu_pkg::WAKE_EN_ADDR)) |=> $stable(wake_en_reg))
        else $error("enables changed without write");

    // Read data answer for one cycle only and carry the live pin levels.
    AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
        !rd_stb |=> (rdata == kwu_pkg::READ_ZERO))
        else $error("read data held");

    AST_STATUS_READ: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_stb && addr_hit(addr, kwu_pkg::KWU_STATUS_ADDR))
        |=> (rdata[kwu_pkg::ST_KEYS_LSB +: 4] == $past(key_wake_in)
             && rdata[kwu_pkg::ST_STOP_BIT] == $past(stop_reg)))
        else $error("status read wrong");

    COV_KEY_WAKE: cover property (@(posedge mclk) disable iff (!rst_n)
        stop_reg && level_mode && !main_release_in && release_req);
    COV_EDGE_WAKE: cover property (@(posedge mclk) disable iff (!rst_n)
        stop_reg && !level_mode && release_req);
    COV_SKIP: cover property (@(posedge mclk) disable iff (!rst_n)
        !stop_reg && stop_entry && release_req);
    COV_MAIN_SKIP: cover property (@(posedge mclk) disable iff (!rst_n)
        !stop_reg && stop_entry && level_mode && main_release_in);
endmodule

// ### dv/kwu_keys_model.sv
// Purpose: Key switches and main release pin outside the wakeup unit.
// Assumes: Keys pull up to high when not pressed.
// Notes:   The bench chooses which keys are pressed.
`timescale 1ns/1ns
module kwu_keys_model (
    input  wire logic [3:0] pressed,
    input  wire logic       main_hi,
    output logic      [3:0] key_wake_in,
    output logic            main_release_in
);
    assign key_wake_in     = ~pressed;
    assign main_release_in = main_hi;
endmodule

// ### dv/key_on_wakeup_stop_release_tb.sv
// Purpose: Self-checking bench for the key-on wakeup unit.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes:   Rows hold enables, pressed keys, main pin, mode and request.
`timescale 1ns/1ns
module key_on_wakeup_stop_release_tb;
    logic        mclk = 1'b0, resetn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic        level_mode = 1'b1, stop_entry = 1'b0, main_hi = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [3:0]  pressed = 4'h0, keys, kpd;
    logic        main_in, req, stop_act, warm;
    int          failures = 0, check_count = 0, cyc = 0;
    localparam logic [10:0] ROWS [7] = '{{4'h0, 4'hf, 3'b010}, {4'h1, 4'h1, 3'b011},
        {4'h1, 4'h2, 3'b010}, {4'h8, 4'h8, 3'b011}, {4'hf, 4'h0, 3'b111},
        {4'hf, 4'hf, 3'b000}, {4'h0, 4'h0, 3'b010}};
    kwu_keys_model far (.pressed(pressed), .main_hi(main_hi), .key_wake_in(keys),
        .main_release_in(main_in));
    kwu_top dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .key_wake_in(keys), .main_release_in(main_in),
        .level_mode(level_mode), .stop_entry(stop_entry), .release_req(req),
        .stop_active(stop_act), .warmup_start(warm), .key_port_data(kpd));
    initial begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [7:0] e);
        @(posedge mclk);
        wr_stb <= w;
        rd_stb <= !w;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        @(negedge mclk);
        if (!w) chk("rdata", e, rdata);
    endtask
    task automatic pins(input logic [3:0] p, input logic m, input logic md);
        @(posedge mclk);
        pressed <= p;
        main_hi <= m;
        level_mode <= md;
        @(negedge mclk);
    endtask
    task automatic stop_go();
        @(posedge mclk);
        stop_entry <= 1'b1;
        @(posedge mclk);
        stop_entry <= 1'b0;
        @(negedge mclk);
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        pins(4'hf, 1'b0, 1'b1);
        chk("req_reset", 8'h00, {7'h0, req});
        acc(1'b1, kwu_pkg::WAKE_EN_ADDR, 8'hf0, 8'h00);
        acc(1'b1, 12'h123, 8'h00, 8'h00);
        chk("en_kept", 8'h01, {7'h0, req});
        acc(1'b0, kwu_pkg::WAKE_EN_ADDR, 8'h00, 8'h00);
        acc(1'b0, 12'h123, 8'h00, 8'h00);
        foreach (ROWS[i]) begin
            acc(1'b1, kwu_pkg::WAKE_EN_ADDR, {ROWS[i][10:7], 4'h5}, 8'h00);
            pins(ROWS[i][6:3], ROWS[i][2], ROWS[i][1]);
            chk("release_req", {7'h0, ROWS[i][0]}, {7'h0, req});
            acc(1'b0, kwu_pkg::KWU_STATUS_ADDR, 8'h00,
                {~ROWS[i][6:3], 1'b0, ROWS[i][1], 1'b0, ROWS[i][0]});
            chk("key_port_data", {4'h0, ~ROWS[i][6:3]}, {4'h0, kpd});
        end
        acc(1'b1, kwu_pkg::WAKE_EN_ADDR, 8'h10, 8'h00);
        pins(4'h1, 1'b0, 1'b1);
        stop_go();
        chk("skip_stop", 8'h01, {6'h0, stop_act, warm});
        pins(4'h0, 1'b0, 1'b1);
        stop_go();
        chk("stop_entered", 8'h02, {6'h0, stop_act, warm});
        pins(4'h1, 1'b0, 1'b1);
        chk("req_in_stop", 8'h01, {7'h0, req});
        @(negedge mclk);
        chk("key_release", 8'h01, {6'h0, stop_act, warm});
        @(negedge mclk);
        chk("warm_pulse", 8'h00, {6'h0, stop_act, warm});
        pins(4'h0, 1'b1, 1'b1);
        stop_go();
        chk("main_skip", 8'h01, {6'h0, stop_act, warm});
        pins(4'h0, 1'b0, 1'b0);
        stop_go();
        chk("edge_stop", 8'h02, {6'h0, stop_act, warm});
        pins(4'h0, 1'b1, 1'b0);
        chk("edge_req", 8'h01, {7'h0, req});
        @(negedge mclk);
        chk("edge_release", 8'h01, {6'h0, stop_act, warm});
        pins(4'h0, 1'b0, 1'b1);
        stop_go();
        chk("stop_again", 8'h02, {6'h0, stop_act, warm});
        @(posedge mclk);
        resetn <= 1'b0;
        @(negedge mclk);
        chk("reset_stop", 8'h00, {6'h0, stop_act, warm});
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        pins(4'h1, 1'b0, 1'b1);
        chk("reset_enable", 8'h00, {7'h0, req});
        final_report();
    end
endmodule
